// ===== core/rpfp_top.v
// receive pause frame processing: classification, per-priority requests, registers
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "rpfp_consts.vh"
module rpfp_top (
	input wire clock, // receive clock, 200 MHz
	input wire nrst, // synchronous reset, active low
	input wire rx_hdr_valid, // one-cycle strobe: parsed frame header below
	input wire [47:0] rx_hdr_dst, // destination address
	input wire [47:0] rx_hdr_src, // source address
	input wire [15:0] rx_hdr_ethertype, // length/type field
	input wire [15:0] rx_hdr_opcode, // mac control opcode
	input wire [7:0] rx_hdr_prio_vec, // priority enable vector of the frame
	input wire [127:0] rx_hdr_quanta, // quanta, priority i at [16i+15:16i]
	input wire rx_hdr_fcs_ok, // frame check sequence good
	input wire [47:0] rx_own_addr, // station unicast address
	input wire [47:0] rx_peer_addr, // expected partner source address
	input wire rx_glob_ctrl_frame_en, // global control processing on
	input wire rx_glob_ctrl_mcast_chk, // global control multicast check
	input wire rx_glob_ctrl_ucast_chk, // global control unicast check
	input wire rx_glob_ctrl_srcaddr_chk, // global control source check
	input wire rx_glob_ctrl_ethertype_chk, // global control type check
	input wire rx_glob_ctrl_opcode_chk, // global control opcode check
	input wire rx_prio_ctrl_frame_en, // priority control processing on
	input wire rx_prio_ctrl_mcast_chk, // priority control multicast check
	input wire rx_prio_ctrl_ucast_chk, // priority control unicast check
	input wire rx_prio_ctrl_srcaddr_chk, // priority control source check
	input wire rx_prio_ctrl_ethertype_chk, // priority control type check
	input wire rx_prio_ctrl_opcode_chk, // priority control opcode check
	input wire rx_glob_pause_frame_en, // global pause processing on
	input wire rx_glob_pause_mcast_chk, // global pause multicast check
	input wire rx_glob_pause_ucast_chk, // global pause unicast check
	input wire rx_glob_pause_srcaddr_chk, // global pause source check
	input wire rx_glob_pause_ethertype_chk, // global pause type check
	input wire rx_glob_pause_opcode_chk, // global pause opcode check
	input wire rx_prio_pause_frame_en, // priority pause processing on
	input wire rx_prio_pause_mcast_chk, // priority pause multicast check
	input wire rx_prio_pause_ucast_chk, // priority pause unicast check
	input wire rx_prio_pause_srcaddr_chk, // priority pause source check
	input wire rx_prio_pause_ethertype_chk, // priority pause type check
	input wire rx_prio_pause_opcode_chk, // priority pause opcode check
	input wire [8:0] rx_pause_prio_enable, // per-priority presentation enable
	input wire [8:0] rx_pause_acknowledge, // per-priority user acknowledge
	output wire [8:0] rx_pause_request, // per-priority pause request
	output wire [8:0] rx_pause_valid, // per-priority quanta valid pulse
	output wire [15:0] rx_pause_quanta_prio0, // quanta, priority 0
	output wire [15:0] rx_pause_quanta_prio1, // quanta, priority 1
	output wire [15:0] rx_pause_quanta_prio2, // quanta, priority 2
	output wire [15:0] rx_pause_quanta_prio3, // quanta, priority 3
	output wire [15:0] rx_pause_quanta_prio4, // quanta, priority 4
	output wire [15:0] rx_pause_quanta_prio5, // quanta, priority 5
	output wire [15:0] rx_pause_quanta_prio6, // quanta, priority 6
	output wire [15:0] rx_pause_quanta_prio7, // quanta, priority 7
	output wire [15:0] rx_pause_quanta_global, // quanta of global pause
	output reg rx_glob_ctrl_rcvd, // one-cycle pulse: global control accepted
	output reg rx_prio_ctrl_rcvd, // one-cycle pulse: priority control accepted
	input wire [3:0] reg_addr, // register byte address
	input wire [31:0] reg_wdata, // register write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	output reg [31:0] reg_rdata, // read data, cycle after the strobe
	output reg irq // level interrupt
);
	localparam NPRIO = `RPFP_NPRIO;
	localparam QW = `RPFP_QW;
	localparam NEV = `RPFP_NEV;

	// shared by every register decode below
	function addr_is;
		input [3:0] addr;
		input [3:0] off;
		begin
			addr_is = (addr == off);
		end
	endfunction

	wire gc_pass;
	wire pc_pass;
	wire gp_pass;
	wire pp_pass;
	wire acc_gc;
	wire acc_pc;
	wire acc_gp;
	wire acc_pp;
	wire is_ctrl_type;
	reg hit_gc;
	reg hit_pc;
	reg hit_gp;
	reg hit_pp;
	reg hit_rej;
	reg [7:0] hit_vec;
	reg [127:0] hit_quanta;
	wire [8:0] slot_load;
	wire [8:0] slot_stray;
	wire [NPRIO*QW-1:0] slot_quanta;
	// sticky event bits, their interrupt enables and next values
	reg [NEV-1:0] status;
	reg [NEV-1:0] irq_en;
	reg [NEV-1:0] next_status;
	reg [NEV-1:0] ev_set;
	reg [NEV-1:0] ev_clr;
	reg [31:0] next_rdata;

	rpfp_hdr_chk #(
		.OPCODE(`RPFP_OP_GLOB_CTRL),
		.EXACT_OP(0)
	) u_chk_gc (
		.mcast_chk(rx_glob_ctrl_mcast_chk),
		.ucast_chk(rx_glob_ctrl_ucast_chk),
		.srcaddr_chk(rx_glob_ctrl_srcaddr_chk),
		.ethertype_chk(rx_glob_ctrl_ethertype_chk),
		.opcode_chk(rx_glob_ctrl_opcode_chk),
		.dst(rx_hdr_dst),
		.src(rx_hdr_src),
		.own_addr(rx_own_addr),
		.peer_addr(rx_peer_addr),
		.ethertype(rx_hdr_ethertype),
		.opcode(rx_hdr_opcode),
		.pass(gc_pass)
	);

	rpfp_hdr_chk #(
		.OPCODE(`RPFP_OP_PRIO_CTRL),
		.EXACT_OP(0)
	) u_chk_pc (
		.mcast_chk(rx_prio_ctrl_mcast_chk),
		.ucast_chk(rx_prio_ctrl_ucast_chk),
		.srcaddr_chk(rx_prio_ctrl_srcaddr_chk),
		.ethertype_chk(rx_prio_ctrl_ethertype_chk),
		.opcode_chk(rx_prio_ctrl_opcode_chk),
		.dst(rx_hdr_dst),
		.src(rx_hdr_src),
		.own_addr(rx_own_addr),
		.peer_addr(rx_peer_addr),
		.ethertype(rx_hdr_ethertype),
		.opcode(rx_hdr_opcode),
		.pass(pc_pass)
	);

	rpfp_hdr_chk #(
		.OPCODE(`RPFP_OP_GLOB_PAUSE),
		.EXACT_OP(1)
	) u_chk_gp (
		.mcast_chk(rx_glob_pause_mcast_chk),
		.ucast_chk(rx_glob_pause_ucast_chk),
		.srcaddr_chk(rx_glob_pause_srcaddr_chk),
		.ethertype_chk(rx_glob_pause_ethertype_chk),
		.opcode_chk(rx_glob_pause_opcode_chk),
		.dst(rx_hdr_dst),
		.src(rx_hdr_src),
		.own_addr(rx_own_addr),
		.peer_addr(rx_peer_addr),
		.ethertype(rx_hdr_ethertype),
		.opcode(rx_hdr_opcode),
		.pass(gp_pass)
	);

	rpfp_hdr_chk #(
		.OPCODE(`RPFP_OP_PRIO_PAUSE),
		.EXACT_OP(1)
	) u_chk_pp (
		.mcast_chk(rx_prio_pause_mcast_chk),
		.ucast_chk(rx_prio_pause_ucast_chk),
		.srcaddr_chk(rx_prio_pause_srcaddr_chk),
		.ethertype_chk(rx_prio_pause_ethertype_chk),
		.opcode_chk(rx_prio_pause_opcode_chk),
		.dst(rx_hdr_dst),
		.src(rx_hdr_src),
		.own_addr(rx_own_addr),
		.peer_addr(rx_peer_addr),
		.ethertype(rx_hdr_ethertype),
		.opcode(rx_hdr_opcode),
		.pass(pp_pass)
	);

	// a frame lands in one class only: pause before control, priority before global,
	// so loose checks on several classes cannot raise two events for one frame
	assign acc_pp = rx_hdr_valid && rx_hdr_fcs_ok && rx_prio_pause_frame_en && pp_pass;
	assign acc_gp = rx_hdr_valid && rx_hdr_fcs_ok && rx_glob_pause_frame_en && gp_pass &&
		!acc_pp;
	assign acc_pc = rx_hdr_valid && rx_hdr_fcs_ok && rx_prio_ctrl_frame_en && pc_pass &&
		!acc_pp && !acc_gp;
	assign acc_gc = rx_hdr_valid && rx_hdr_fcs_ok && rx_glob_ctrl_frame_en && gc_pass &&
		!acc_pp && !acc_gp && !acc_pc;
	assign is_ctrl_type = rx_hdr_ethertype == `RPFP_MAC_CTRL_TYPE;

	// one register stage after the compares keeps the wide address match off the slot path
	always @(posedge clock) begin
		if (!nrst) begin
			hit_gc <= 1'b0;
			hit_pc <= 1'b0;
			hit_gp <= 1'b0;
			hit_pp <= 1'b0;
			hit_rej <= 1'b0;
			hit_vec <= 8'h00;
			hit_quanta <= 128'h0;
			rx_glob_ctrl_rcvd <= 1'b0;
			rx_prio_ctrl_rcvd <= 1'b0;
		end else begin
			hit_gc <= acc_gc;
			hit_pc <= acc_pc;
			hit_gp <= acc_gp;
			hit_pp <= acc_pp;
			// a mac control frame that no enabled class took
			hit_rej <= rx_hdr_valid && is_ctrl_type &&
				!acc_pp && !acc_gp && !acc_pc && !acc_gc;
			hit_vec <= rx_hdr_prio_vec;
			hit_quanta <= rx_hdr_quanta;
			rx_glob_ctrl_rcvd <= acc_gc;
			rx_prio_ctrl_rcvd <= acc_pc;
		end
	end

	// slot 8 holds the global pause; it takes the lowest quanta word
	genvar gi;
	generate
		for (gi = 0; gi < NPRIO; gi = gi + 1) begin : g_slot
			wire [15:0] qin;
			if (gi == `RPFP_GLOB_IDX) begin : g_glob
				assign slot_load[gi] = hit_gp;
				assign qin = hit_quanta[QW-1:0];
			end else begin : g_prio
				// loads only when the frame's priority vector names this slot
				assign slot_load[gi] = hit_pp && hit_vec[gi];
				assign qin = hit_quanta[gi*QW +: QW];
			end
			rpfp_slot u_slot (
				.clock(clock),
				.nrst(nrst),
				.load(slot_load[gi]),
				.quanta_in(qin),
				.enable(rx_pause_prio_enable[gi]),
				.ack(rx_pause_acknowledge[gi]),
				.req(rx_pause_request[gi]),
				.valid(rx_pause_valid[gi]),
				.quanta(slot_quanta[gi*QW +: QW]),
				.stray_ack(slot_stray[gi])
			);
		end
	endgenerate

	// each quanta output keeps the last presented value
	assign rx_pause_quanta_prio0 = slot_quanta[0*QW +: QW];
	assign rx_pause_quanta_prio1 = slot_quanta[1*QW +: QW];
	assign rx_pause_quanta_prio2 = slot_quanta[2*QW +: QW];
	assign rx_pause_quanta_prio3 = slot_quanta[3*QW +: QW];
	assign rx_pause_quanta_prio4 = slot_quanta[4*QW +: QW];
	assign rx_pause_quanta_prio5 = slot_quanta[5*QW +: QW];
	assign rx_pause_quanta_prio6 = slot_quanta[6*QW +: QW];
	assign rx_pause_quanta_prio7 = slot_quanta[7*QW +: QW];
	assign rx_pause_quanta_global = slot_quanta[`RPFP_GLOB_IDX*QW +: QW];

	// status events ignore the presentation enables: only the user view is gated
	always @* begin
		ev_set = {NEV{1'b0}};
		ev_set[`RPFP_EV_GLOB_CTRL] = hit_gc;
		ev_set[`RPFP_EV_PRIO_CTRL] = hit_pc;
		ev_set[`RPFP_EV_GLOB_PAUSE] = hit_gp;
		ev_set[`RPFP_EV_PRIO_PAUSE] = hit_pp;
		ev_set[`RPFP_EV_REJECT] = hit_rej;
		// an acknowledge with nothing pending is only logged
		ev_set[`RPFP_EV_STRAY_ACK] = |slot_stray;
		ev_clr = {NEV{1'b0}};
		if (reg_wr && addr_is(reg_addr, `RPFP_REG_CLEAR)) begin
			ev_clr = reg_wdata[NEV-1:0];
		end
		// set wins so an event in the clear cycle is kept
		next_status = (status & ~ev_clr) | ev_set;
	end

	// read data stands only in the cycle after the strobe, zero otherwise
	always @* begin
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			if (addr_is(reg_addr, `RPFP_REG_STATUS)) begin
				next_rdata[NEV-1:0] = status;
			end else if (addr_is(reg_addr, `RPFP_REG_IRQ_EN)) begin
				next_rdata[NEV-1:0] = irq_en;
			end else if (addr_is(reg_addr, `RPFP_REG_PENDING)) begin
				next_rdata[NPRIO-1:0] = rx_pause_request;
			end
		end
	end

	// the clear register keeps no state; it acts through next_status only
	always @(posedge clock) begin
		if (!nrst) begin
			status <= {NEV{1'b0}};
			irq_en <= {NEV{1'b0}};
			reg_rdata <= 32'h0000_0000;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			if (reg_wr && addr_is(reg_addr, `RPFP_REG_IRQ_EN)) begin
				irq_en <= reg_wdata[NEV-1:0];
			end
			reg_rdata <= next_rdata;
			// registered from next values so irq follows status with no extra lag
			if (reg_wr && addr_is(reg_addr, `RPFP_REG_IRQ_EN)) begin
				irq <= |(next_status & reg_wdata[NEV-1:0]);
			end else begin
				irq <= |(next_status & irq_en);
			end
		end
	end
endmodule // rpfp_top

// ===== inc/rpfp_consts.vh
// constants for the receive pause frame processing block
`ifndef RPFP_CONSTS_VH
`define RPFP_CONSTS_VH

`define RPFP_NPRIO 9
`define RPFP_GLOB_IDX 8
`define RPFP_QW 16
`define RPFP_MAC_CTRL_TYPE 16'h8808
`define RPFP_OP_GLOB_PAUSE 16'h0001
`define RPFP_OP_PRIO_PAUSE 16'h0101
`define RPFP_OP_GLOB_CTRL 16'h0000
`define RPFP_OP_PRIO_CTRL 16'h0100
`define RPFP_MCAST_DA 48'h0180_c200_0001

`define RPFP_AW 4
`define RPFP_DW 32
`define RPFP_REG_STATUS 4'h0
`define RPFP_REG_IRQ_EN 4'h4
`define RPFP_REG_CLEAR 4'h8
`define RPFP_REG_PENDING 4'hc

`define RPFP_NEV 6
`define RPFP_EV_GLOB_CTRL 0
`define RPFP_EV_PRIO_CTRL 1
`define RPFP_EV_GLOB_PAUSE 2
`define RPFP_EV_PRIO_PAUSE 3
`define RPFP_EV_REJECT 4
`define RPFP_EV_STRAY_ACK 5

`endif

// ===== core/rpfp_hdr_chk.v
// header checker for one control/pause frame class
`timescale 1ns/1ps
module rpfp_hdr_chk #(
	parameter [15:0] OPCODE = 16'h0001,
	parameter EXACT_OP = 1
) (
	input wire mcast_chk, // multicast destination check on
	input wire ucast_chk, // unicast destination check on
	input wire srcaddr_chk, // source address check on
	input wire ethertype_chk, // ethertype check on
	input wire opcode_chk, // opcode check on
	input wire [47:0] dst, // frame destination address
	input wire [47:0] src, // frame source address
	input wire [47:0] own_addr, // station unicast address
	input wire [47:0] peer_addr, // expected link partner address
	input wire [15:0] ethertype, // frame length/type field
	input wire [15:0] opcode, // mac control opcode
	output wire pass // all enabled checks agree; with both destination checks on, one of the two is enough
);
	wire da_ok;
	wire sa_ok;
	wire et_ok;
	wire op_ok;
	wire op_match;

	// with both destination checks on either address is accepted
	assign da_ok = (!mcast_chk && !ucast_chk) || (mcast_chk && dst == `RPFP_MCAST_DA) ||
		(ucast_chk && dst == own_addr);
	assign sa_ok = !srcaddr_chk || src == peer_addr;
	assign et_ok = !ethertype_chk || ethertype == `RPFP_MAC_CTRL_TYPE;
	// control classes take any opcode of their family except the pause one
	assign op_match = EXACT_OP ? (opcode == OPCODE) :
		(opcode[15:8] == OPCODE[15:8] &&
		opcode != `RPFP_OP_GLOB_PAUSE && opcode != `RPFP_OP_PRIO_PAUSE);
	assign op_ok = !opcode_chk || op_match;
	assign pass = da_ok && sa_ok && et_ok && op_ok;
endmodule // rpfp_hdr_chk

// ===== core/rpfp_slot.v
// one priority's pause request, valid flag and quanta holder
`timescale 1ns/1ps
`include "rpfp_consts.vh"
module rpfp_slot (
	input wire clock, // receive clock
	input wire nrst, // synchronous reset, active low
	input wire load, // accepted pause for this priority
	input wire [15:0] quanta_in, // quanta of the accepted frame
	input wire enable, // user presentation enable
	input wire ack, // user acknowledge
	output reg req, // pause request, held until acknowledged
	output reg valid, // one-cycle quanta valid pulse
	output reg [15:0] quanta, // last presented quanta
	output reg stray_ack // ack seen with no request pending
);
	wire take;

	assign take = load && enable;
	always @(posedge clock) begin
		if (!nrst) begin
			req <= 1'b0;
			valid <= 1'b0;
			quanta <= 16'h0000;
			stray_ack <= 1'b0;
		end else begin
			valid <= take;
			if (take) begin
				quanta <= quanta_in;
			end
			// a new frame in the ack cycle keeps the request up
			req <= take || (req && !ack);
			stray_ack <= ack && !req;
		end
	end
endmodule // rpfp_slot

// ===== verif/rpfp_chk.sv
// assertion checker for the receive pause frame block
`timescale 1ns/1ps
module rpfp_chk (
	input wire clock, // rx clock
	input wire nrst, // sync reset
	input wire rx_hdr_valid, // header strobe
	input wire rx_hdr_fcs_ok, // fcs good
	input wire [127:0] rx_hdr_quanta, // quanta in
	input wire rx_glob_ctrl_frame_en, // class on
	input wire rx_prio_ctrl_frame_en, // class on
	input wire rx_glob_pause_frame_en, // class on
	input wire rx_prio_pause_frame_en, // class on
	input wire [8:0] rx_pause_acknowledge, // user ack
	input wire [8:0] rx_pause_request, // request
	input wire [8:0] rx_pause_valid, // valid
	input wire [15:0] rx_pause_quanta_global, // global quanta
	input wire rx_glob_ctrl_rcvd, // ctrl pulse
	input wire rx_prio_ctrl_rcvd // ctrl pulse
);
default clocking @(posedge clock); endclocking
default disable iff (!nrst);
// the valid pulse always comes two edges after its header
sequence s_glob_seen;
	rx_hdr_valid ##2 rx_pause_valid[8];
endsequence
sequence s_prio_seen;
	rx_hdr_valid ##2 (|rx_pause_valid[7:0]);
endsequence
glob_pause_en_a: assert property (
	s_glob_seen |-> $past(rx_glob_pause_frame_en && rx_hdr_fcs_ok, 2)) else $error("bad glob");
glob_quanta_a: assert property (
	s_glob_seen |-> rx_pause_quanta_global == $past(rx_hdr_quanta[15:0], 2))
	else $error("bad glob quanta");
prio_pause_en_a: assert property (
	s_prio_seen |-> $past(rx_prio_pause_frame_en && rx_hdr_fcs_ok, 2)) else $error("bad prio");
valid_has_req_a: assert property (
	(rx_pause_valid & ~rx_pause_request) == 9'h000) else $error("valid without request");
req_rise_a: assert property (
	(rx_pause_request & ~$past(rx_pause_request) & ~rx_pause_valid) == 9'h000)
	else $error("request without frame");
req_hold_a: assert property (
	1'b1 |=> ($past(rx_pause_request & ~rx_pause_acknowledge) & ~rx_pause_request) == 9'h000)
	else $error("request dropped early");
ack_clear_a: assert property (
	|(rx_pause_request & rx_pause_acknowledge) |=> ($past(rx_pause_request
	& rx_pause_acknowledge) & rx_pause_request & ~rx_pause_valid) == 9'h000)
	else $error("request kept after ack");
glob_ctrl_en_a: assert property (
	rx_glob_ctrl_rcvd |-> $past(rx_hdr_valid && rx_hdr_fcs_ok && rx_glob_ctrl_frame_en))
	else $error("bad glob ctrl");
prio_ctrl_en_a: assert property (
	rx_prio_ctrl_rcvd |-> $past(rx_hdr_valid && rx_hdr_fcs_ok && rx_prio_ctrl_frame_en))
	else $error("bad prio ctrl");
endmodule // rpfp_chk
bind rpfp_top rpfp_chk u_chk (.clock, .nrst, .rx_hdr_valid, .rx_hdr_fcs_ok, .rx_hdr_quanta,
	.rx_glob_ctrl_frame_en, .rx_prio_ctrl_frame_en, .rx_glob_pause_frame_en,
	.rx_prio_pause_frame_en, .rx_pause_acknowledge, .rx_pause_request, .rx_pause_valid,
	.rx_pause_quanta_global, .rx_glob_ctrl_rcvd, .rx_prio_ctrl_rcvd);

// ===== verif/rpfp_user.sv
// user-side pause handler model: acknowledges requests after a delay
`timescale 1ns/1ps
module rpfp_user (
	input wire clock, // rx clock
	input wire nrst, // sync reset
	input wire slow, // wait before acking
	input wire [8:0] req, // requests
	output reg [8:0] ack // one-cycle acks
);
reg [3:0] cnt;
always @(posedge clock) begin
	if (!nrst) begin
		ack <= 9'h000;
		cnt <= 4'h0;
	end else begin
		ack <= 9'h000;
		// only pending bits are acked, never a stray one
		if (req == 9'h000 || ack != 9'h000) begin
			cnt <= 4'h0;
		end else if (cnt == (slow ? 4'h6 : 4'h0)) begin
			ack <= req;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
end
endmodule // rpfp_user

// ===== verif/tb_rpfp_top.sv
// self-checking bench for the receive pause frame block
`timescale 1ns/1ps
module tb_rpfp_top;
localparam [47:0] mc_da = 48'h0180_c200_0001;
localparam [47:0] own_da = 48'h0200_0000_00a1;
localparam [47:0] peer_sa = 48'h0200_0000_00b2;
reg clock = 1'b0, nrst = 1'b0, hv = 1'b0, fcs = 1'b0, slow = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
reg [47:0] da = '0, sa = '0;
reg [15:0] et = '0, op = '0;
reg [7:0] vec = '0;
reg [5:0] gc = 6'h3f, pc = 6'h3f, gp = 6'h3f, pp = 6'h3f;
reg [8:0] pe = 9'h1ff;
reg [127:0] qv = 128'h1007_1006_1005_1004_1003_1002_1001_1000;
reg [3:0] reg_addr = '0;
reg [31:0] reg_wdata = '0;
wire [8:0] ack, req, val;
wire [15:0] q [0:8];
wire [31:0] reg_rdata;
wire gcr, pcr, irq;
reg [1:0] rc;
reg [8:0] rq, rv;
integer bad_count = 0, compares = 0, cyc = 0, b, n;
rpfp_top DUT (.clock(clock), .nrst(nrst), .rx_hdr_valid(hv), .rx_hdr_dst(da), .rx_hdr_src(sa),
	.rx_hdr_ethertype(et), .rx_hdr_opcode(op), .rx_hdr_prio_vec(vec), .rx_hdr_fcs_ok(fcs),
	.rx_hdr_quanta(qv),
	.rx_own_addr(own_da), .rx_peer_addr(peer_sa),
	.rx_glob_ctrl_frame_en(gc[0]), .rx_glob_ctrl_mcast_chk(gc[1]), .rx_glob_ctrl_ucast_chk(gc[2]),
	.rx_glob_ctrl_srcaddr_chk(gc[3]), .rx_glob_ctrl_ethertype_chk(gc[4]),
	.rx_glob_ctrl_opcode_chk(gc[5]), .rx_prio_ctrl_frame_en(pc[0]),
	.rx_prio_ctrl_mcast_chk(pc[1]), .rx_prio_ctrl_ucast_chk(pc[2]),
	.rx_prio_ctrl_srcaddr_chk(pc[3]), .rx_prio_ctrl_ethertype_chk(pc[4]),
	.rx_prio_ctrl_opcode_chk(pc[5]), .rx_glob_pause_frame_en(gp[0]),
	.rx_glob_pause_mcast_chk(gp[1]), .rx_glob_pause_ucast_chk(gp[2]),
	.rx_glob_pause_srcaddr_chk(gp[3]), .rx_glob_pause_ethertype_chk(gp[4]),
	.rx_glob_pause_opcode_chk(gp[5]), .rx_prio_pause_frame_en(pp[0]),
	.rx_prio_pause_mcast_chk(pp[1]), .rx_prio_pause_ucast_chk(pp[2]),
	.rx_prio_pause_srcaddr_chk(pp[3]), .rx_prio_pause_ethertype_chk(pp[4]),
	.rx_prio_pause_opcode_chk(pp[5]), .rx_pause_prio_enable(pe), .rx_pause_acknowledge(ack),
	.rx_pause_request(req), .rx_pause_valid(val), .rx_pause_quanta_prio0(q[0]),
	.rx_pause_quanta_prio1(q[1]), .rx_pause_quanta_prio2(q[2]), .rx_pause_quanta_prio3(q[3]),
	.rx_pause_quanta_prio4(q[4]), .rx_pause_quanta_prio5(q[5]), .rx_pause_quanta_prio6(q[6]),
	.rx_pause_quanta_prio7(q[7]), .rx_pause_quanta_global(q[8]), .rx_glob_ctrl_rcvd(gcr),
	.rx_prio_ctrl_rcvd(pcr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
rpfp_user u_user (.clock(clock), .nrst(nrst), .slow(slow), .req(req), .ack(ack));
always #2.5 clock = ~clock;
always @(posedge clock) begin
	cyc <= cyc + 1;
	if (cyc == 3000) begin
		bad_count = bad_count + 1;
		end_of_test;
	end
end
task end_of_test;
	$display("compares %0d bad_count %0d", compares, bad_count);
	if (bad_count == 0 && compares > 0) begin
		$display("Testbench passed");
	end else begin
		$display("Testbench failed");
	end
	$finish;
endtask
task chk(input [31:0] got, input [31:0] exp);
	compares = compares + 1;
	if (got !== exp) begin
		bad_count = bad_count + 1;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	end
endtask
// bd: 0 good, 1 wrong source, 2 bad fcs, 3 wrong ethertype
task send(input [15:0] o, input [47:0] d, input integer bd);
	@(posedge clock);
	hv <= 1'b1;
	op <= o;
	da <= d;
	sa <= (bd == 1) ? own_da : peer_sa;
	fcs <= (bd != 2);
	et <= (bd == 3) ? 16'h0800 : 16'h8808;
	@(posedge clock);
	hv <= 1'b0;
	#1 rc = {pcr, gcr};
	@(posedge clock);
	#1 rq = req;
	rv = val;
endtask
task drain;
	for (n = 0; n < 20 && req !== 9'h000; n = n + 1) begin
		@(posedge clock);
		#1;
	end
	chk(req, 9'h000);
endtask
task wr(input [3:0] a, input [31:0] d);
	@(posedge clock);
	reg_wr <= 1'b1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clock);
	reg_wr <= 1'b0;
endtask
task rd(input [3:0] a, input [31:0] e);
	@(posedge clock);
	reg_rd <= 1'b1;
	reg_addr <= a;
	@(posedge clock);
	reg_rd <= 1'b0;
	#1 chk(reg_rdata, e);
endtask
task t_prio;
	@(posedge clock);
	slow <= 1'b1;
	vec <= 8'h05;
	send(16'h0101, mc_da, 0);
	chk(rq, 9'h005);
	chk(rv, 9'h005);
	chk(q[0], 16'h1000);
	chk(q[2], 16'h1002);
	repeat (4) @(posedge clock);
	#1 chk(req, 9'h005);
	rd(4'hc, 32'h0000_0005);
	drain;
	@(posedge clock);
	vec <= 8'hfa;
	send(16'h0101, mc_da, 0);
	chk(rq, 9'h0fa);
	chk(rv, 9'h0fa);
	for (n = 1; n < 8; n = n + 1) begin
		if (vec[n]) begin
			chk(q[n], 16'h1000 + n);
		end
	end
	drain;
	@(posedge clock);
	vec <= 8'h05;
endtask
task t_glob;
	@(posedge clock);
	slow <= 1'b0;
	qv[15:0] <= 16'h2345;
	send(16'h0001, own_da, 0);
	chk(rq, 9'h100);
	chk(rv, 9'h100);
	chk(q[8], 16'h2345);
	chk(q[0], 16'h1000);
	drain;
endtask
task t_refuse;
	for (b = 1; b < 4; b = b + 1) begin
		send(16'h0101, mc_da, b);
		chk(rq, 9'h000);
		send(16'h0001, own_da, b);
		chk(rq, 9'h000);
	end
	@(posedge clock);
	pp <= 6'h37;
	gp <= 6'h2f;
	send(16'h0101, mc_da, 1);
	chk(rq, 9'h005);
	send(16'h0001, own_da, 3);
	chk(rq, 9'h100);
	drain;
	@(posedge clock);
	pp <= 6'h3e;
	gp <= 6'h3e;
	send(16'h0101, mc_da, 0);
	chk(rq, 9'h000);
	send(16'h0001, own_da, 0);
	chk(rq, 9'h000);
	@(posedge clock);
	pp <= 6'h3b;
	gp <= 6'h3d;
	send(16'h0101, own_da, 0);
	chk(rq, 9'h000);
	send(16'h0001, mc_da, 0);
	chk(rq, 9'h000);
	@(posedge clock);
	pp <= 6'h39;
	send(16'h0101, 48'h0200_0000_00c3, 0);
	chk(rq, 9'h005);
	drain;
	@(posedge clock);
	pp <= 6'h3f;
	gp <= 6'h3f;
endtask
task t_ctrl;
	for (b = 0; b < 2; b = b + 1) begin
		@(posedge clock);
		gc <= {5'h1f, b[0]};
		pc <= {5'h1f, b[0]};
		send(16'h0000, mc_da, 0);
		chk(rc, {1'b0, b[0]});
		send(16'h0100, mc_da, 0);
		chk(rc, {b[0], 1'b0});
		send(16'h0000, mc_da, 1);
		chk(rc, 2'b00);
		send(16'h0100, mc_da, 3);
		chk(rc, 2'b00);
	end
endtask
task t_regs;
	rd(4'h0, 32'h0000_001f);
	wr(4'h8, 32'h0000_003f);
	rd(4'h0, 32'h0000_0000);
	@(posedge clock);
	pe <= 9'h0ff;
	send(16'h0001, own_da, 0);
	chk(rq, 9'h000);
	send(16'h0001, own_da, 2);
	chk(rq, 9'h000);
	rd(4'h0, 32'h0000_0014);
	wr(4'h4, 32'h0000_0004);
	repeat (2) @(posedge clock);
	#1 chk(irq, 1'b1);
	wr(4'h4, 32'h0000_0000);
	repeat (2) @(posedge clock);
	#1 chk(irq, 1'b0);
	wr(4'h8, 32'h0000_0004);
	wr(4'h4, 32'h0000_0004);
	repeat (2) @(posedge clock);
	#1 chk(irq, 1'b0);
	rd(4'h4, 32'h0000_0004);
	rd(4'h8, 32'h0000_0000);
	rd(4'h2, 32'h0000_0000);
	rd(4'h0, 32'h0000_0010);
	@(posedge clock);
	pe <= 9'h1ff;
endtask
initial begin
	repeat (4) @(posedge clock);
	nrst <= 1'b1;
	t_prio;
	t_glob;
	t_refuse;
	t_ctrl;
	t_regs;
	end_of_test;
end
endmodule // tb_rpfp_top
